//--- design/sad_decode_timing.sv
// Subranging converter timing, latching and decoding logic
`timescale 1ns/1ps
module sad_decode_timing (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Comparator rows, high when signal above reference
    input wire logic [2:0] cmpRowOne,
    input wire logic [6:0] cmpRowTwo,
    input wire logic [6:0] cmpRowThree,
    // Analogue control
    output logic samplePulse,
    output logic [1:0] currentTop,
    output logic [2:0] currentMid,
    // Clock phases
    output logic clock_phase_one,
    output logic clock_phase_two,
    output logic clock_phase_three,
    output logic clock_phase_four,
    output logic clock_phase_five,
    // Store side
    output logic [sad_pkg::WORD_WIDTH-1:0] dataWord,
    output logic dataValid
);
    import sad_pkg::*;

    logic [PHASE_COUNT-1:0] phase;
    logic [3:0] subCount;
    logic oscHigh;

    sad_phase_gen u_phase (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .phaseOneHot(phase),
        .subCount(subCount),
        .oscHigh(oscHigh)
    );

    assign clock_phase_one = phase[0];
    assign clock_phase_two = phase[1];
    assign clock_phase_three = phase[2];
    assign clock_phase_four = phase[3];
    assign clock_phase_five = phase[4];

    // Strobes: a phase gated with an oscillator sub-position
    wire strobeSlot = (subCount == STROBE_SUB) && !oscHigh;
    wire sampleNext = phase[0] && (subCount < SAMPLE_SUB);
    wire latchOneStb = phase[1] && strobeSlot;
    wire latchTwoStb = phase[2] && strobeSlot;
    wire latchThreeStb = phase[3] && strobeSlot;
    wire wordStb = phase[4] && strobeSlot;

    // Delay line standing in for the four inverters
    logic [LATE_DELAY-1:0] lateReg;
    wire lateStb = lateReg[LATE_DELAY-1];

    logic [1:0] topReg;
    logic [1:0] midUpperReg;
    logic midLowReg;
    logic [1:0] lowUpperReg;
    logic [WORD_WIDTH-1:0] wordReg;
    logic validReg;
    logic sampleReg;

    // Upper comparators of a seven-row are those at 2/8, 4/8, 6/8
    wire [2:0] midUpperCmp = {cmpRowTwo[5], cmpRowTwo[3], cmpRowTwo[1]};
    wire [2:0] lowUpperCmp = {cmpRowThree[5], cmpRowThree[3],
        cmpRowThree[1]};
    // Lowest middle bit straight from raw comparators
    wire midLowComb = sad_lsb7(cmpRowTwo);
    // Final lowest bit not latched; only captured into the word
    wire lowLsbComb = sad_lsb7(cmpRowThree);
    wire [WORD_WIDTH-1:0] wordNext = {topReg, midUpperReg, midLowReg,
        lowUpperReg, lowLsbComb};
    // Upper pair is decoded to binary from the raw comparators, then latched
    wire [1:0] topDecoded = sad_dec3(cmpRowOne);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lateReg <= '0;
            sampleReg <= 1'b0;
            topReg <= 2'b00;
            midUpperReg <= 2'b00;
            midLowReg <= 1'b0;
            lowUpperReg <= 2'b00;
            wordReg <= WORD_RESET;
            validReg <= 1'b0;
        end else begin
            lateReg <= {lateReg[LATE_DELAY-2:0], latchTwoStb};
            sampleReg <= sampleNext;
            validReg <= wordStb;
            if (latchOneStb) begin
                topReg <= topDecoded;
            end
            if (latchTwoStb) begin
                midUpperReg <= sad_dec3(midUpperCmp);
            end
            if (lateStb) begin
                midLowReg <= midLowComb;
            end
            if (latchThreeStb) begin
                lowUpperReg <= sad_dec3(lowUpperCmp);
            end
            if (wordStb) begin
                wordReg <= wordNext;
            end
        end
    end

    // High bit turns its source on; weights fixed in the analogue part
    assign currentTop = topReg;
    assign currentMid = {midUpperReg, midLowReg};
    assign samplePulse = sampleReg;
    assign dataWord = wordReg;
    assign dataValid = validReg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_sample_width: assert property ($rose(samplePulse) |->
        samplePulse[*8] ##1 samplePulse ##1 samplePulse ##1 !samplePulse)
        else $error("sample pulse not 100 ns");
    chk_conv_period: assert property ($rose(samplePulse) |->
        ##55 $rose(samplePulse))
        else $error("conversion period not 550 ns");
    chk_first_settle: assert property ($fell(samplePulse) |->
        ##9 latchOneStb)
        else $error("first row not latched 100 ns after sample");
    chk_top_decode: assert property (latchOneStb |=>
        currentTop == sad_dec3($past(cmpRowOne)))
        else $error("top bits wrong");
    chk_late_strobe: assert property (latchTwoStb |->
        ##4 lateStb)
        else $error("late strobe not four cycles after row two latch");
    chk_mid_decode: assert property (lateStb |=>
        currentMid[0] == sad_lsb7($past(cmpRowTwo)))
        else $error("middle low bit wrong");
    chk_row_order: assert property (latchOneStb |->
        ##11 latchTwoStb ##11 latchThreeStb ##11 wordStb)
        else $error("row strobes out of order");
    chk_word_pack: assert property (wordStb |=> dataValid &&
        dataWord[7:6] == $past(topReg) &&
        dataWord[0] == sad_lsb7($past(cmpRowThree)))
        else $error("word packing wrong");
    chk_valid_single: assert property (dataValid |=>
        !dataValid[*8])
        else $error("data valid longer than one cycle");

    // Per-row decode, checked at the register that feeds each stage
    chk_mid_upper: assert property (latchTwoStb |=>
        currentMid[2:1] == sad_dec3($past(midUpperCmp)))
        else $error("middle upper bits wrong");

    chk_low_upper: assert property (latchThreeStb |=>
        lowUpperReg == sad_dec3($past(lowUpperCmp)))
        else $error("low upper bits wrong");

    chk_word_middle: assert property (wordStb |=>
        dataWord[5:3] == $past(currentMid))
        else $error("word middle bits wrong");

    chk_word_low: assert property (wordStb |=>
        dataWord[2:1] == $past(lowUpperReg))
        else $error("word low upper bits wrong");

    // Sample and word pulses tied to their phases
    chk_sample_phase: assert property (samplePulse |->
        $past(clock_phase_one))
        else $error("sample pulse outside phase one");

    chk_valid_phase: assert property (dataValid |->
        $past(clock_phase_five))
        else $error("word outside phase five");

    chk_sample_once: assert property ($fell(samplePulse) |->
        !samplePulse[*8])
        else $error("second sample pulse too soon");

    chk_phase_pins: assert property ($onehot({clock_phase_five,
        clock_phase_four, clock_phase_three, clock_phase_two,
        clock_phase_one}))
        else $error("phase pins not one-hot");

    // Sources must hold between strobes, or the remainder drifts
    chk_top_hold: assert property (!$past(latchOneStb) |->
        $stable(currentTop))
        else $error("top sources changed without strobe");

    chk_mid_hold: assert property (!$past(latchTwoStb) &&
        !$past(lateStb) |-> $stable(currentMid))
        else $error("middle sources changed without strobe");

    chk_word_hold: assert property (!$past(wordStb) |->
        $stable(dataWord))
        else $error("word changed without strobe");

    cov_sample: cover property ($rose(samplePulse));
    cov_full_word: cover property (dataValid && dataWord == 8'hff);
    cov_zero_word: cover property (dataValid && dataWord == 8'h00);
    cov_two_words: cover property (dataValid ##55 dataValid);
    cov_late_lsb: cover property (lateStb && midLowComb);
endmodule

//--- design/sad_pkg.sv
// Constants, timing counts and thermometer decoding for the converter logic
package sad_pkg;
    // System clock
    localparam int CLK_PERIOD_NS = 10;
    // Oscillator and derived timing
    localparam int OSC_FREQ_KHZ = 9090;
    localparam int OSC_PERIOD_NS = 1000000 / OSC_FREQ_KHZ;
    localparam int OSC_CYC = (OSC_PERIOD_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int PHASE_COUNT = 5;
    localparam int PHASE_FREQ_KHZ = 1820;
    localparam int CONV_PERIOD_NS = 550;
    localparam int CONV_CYC = CONV_PERIOD_NS / CLK_PERIOD_NS;
    // Sample pulse and comparator settling
    localparam int SAMPLE_NS = 100;
    localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_NS = 100;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Strobe position within a phase, in the low half of the oscillator
    localparam logic [3:0] STROBE_SUB = 4'(SAMPLE_CYC + SETTLE_CYC - OSC_CYC);
    localparam logic [3:0] SAMPLE_SUB = 4'(SAMPLE_CYC);
    localparam logic [3:0] OSC_LAST = 4'(OSC_CYC - 1);
    localparam logic [3:0] OSC_HALF = 4'((OSC_CYC + 1) / 2);
    // Four inverter stages, one clock each
    localparam int LATE_DELAY = 4;
    // Word layout
    localparam int WORD_WIDTH = 8;
    localparam int LEVELS = 256;
    localparam int TOP_MSB = 7;
    localparam int MID_MSB = 5;
    localparam int LOW_MSB = 2;
    // Switched source weights in 32nds of full scale
    localparam int WEIGHT_TOP1 = 16;
    localparam int WEIGHT_TOP0 = 8;
    localparam int WEIGHT_MID2 = 4;
    localparam int WEIGHT_MID1 = 2;
    localparam int WEIGHT_MID0 = 1;
    // Reset values
    localparam logic [7:0] WORD_RESET = 8'h00;

    // Three-comparator thermometer to 2 bits
    function automatic logic [1:0] sad_dec3(input logic [2:0] c);
        sad_dec3 = {c[1], (c[0] & ~c[1]) | c[2]};
    endfunction

    // Seven-comparator thermometer, lowest bit only
    function automatic logic sad_lsb7(input logic [6:0] c);
        sad_lsb7 = (c[0] & ~c[1]) | (c[2] & ~c[3]) | (c[4] & ~c[5]) | c[6];
    endfunction
endpackage

//--- design/sad_phase_gen.sv
// Oscillator divider and five-phase clock generator
`timescale 1ns/1ps
module sad_phase_gen (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Phase outputs
    output logic [sad_pkg::PHASE_COUNT-1:0] phaseOneHot,
    output logic [3:0] subCount,
    output logic oscHigh
);
    import sad_pkg::*;

    logic [3:0] subReg, subNext;
    logic [PHASE_COUNT-1:0] phaseReg, phaseNext;
    wire oscTick = (subReg == OSC_LAST);

    // Oscillator period emulated as a count of system clocks
    assign subNext = oscTick ? 4'h0 : 4'(subReg + 4'h1);
    // Phase ring advances once per oscillator period
    assign phaseNext = oscTick ?
        {phaseReg[PHASE_COUNT-2:0], phaseReg[PHASE_COUNT-1]} : phaseReg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            subReg <= 4'h0;
            phaseReg <= PHASE_COUNT'(1);
        end else begin
            subReg <= subNext;
            phaseReg <= phaseNext;
        end
    end

    assign phaseOneHot = phaseReg;
    assign subCount = subReg;
    assign oscHigh = (subReg < OSC_HALF);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_phase_ring: assert property ($onehot(phaseReg))
        else $error("phase ring not one-hot");
    chk_phase_step: assert property (phaseReg[0] && subReg == 4'h0 |->
        ##11 phaseReg[1] ##11 phaseReg[2])
        else $error("phase does not last one oscillator period");
endmodule

//--- bench/sad_cmp_model.sv
// Comparator rows and sample-and-hold facing the decode logic
`timescale 1ns/1ps
module sad_cmp_model (
    // Clock
    input wire logic clk_sys,
    // From the decode logic
    input wire logic samplePulse,
    input wire logic [1:0] currentTop,
    input wire logic [2:0] currentMid,
    // Analogue input, expressed as a code
    input wire logic [7:0] level,
    // Comparator rows
    output logic [2:0] cmpRowOne,
    output logic [6:0] cmpRowTwo,
    output logic [6:0] cmpRowThree
);
    int held = 0;
    int rem1;
    int rem2;

    // Tracks while the pulse is high, holds after it
    always @(posedge clk_sys) begin
        if (samplePulse === 1'b1) held <= int'(level);
    end
    // A stale source setting between rows only skews unsampled outputs
    assign rem1 = held - 64 * int'(currentTop);
    assign rem2 = rem1 - 8 * int'(currentMid);
    // Code centre lies above a reference at the same code
    always_comb begin
        for (int k = 0; k < 7; k++) begin
            cmpRowTwo[k] = rem1 >= 8 * (k + 1);
            cmpRowThree[k] = rem2 >= k + 1;
        end
        for (int k = 0; k < 3; k++) begin
            cmpRowOne[k] = held >= 64 * (k + 1);
        end
    end
endmodule

//--- bench/tb_top.sv
// Testbench for the converter timing and decode logic
`timescale 1ns/1ps
module tb_top;
    import sad_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] level = 8'h00;
    logic [2:0] cmpRowOne;
    logic [6:0] cmpRowTwo, cmpRowThree;
    logic samplePulse, dataValid;
    logic [1:0] currentTop;
    logic [2:0] currentMid;
    logic [4:0] ph;
    logic [7:0] dataWord;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    always #5 clk_sys = ~clk_sys;

    sad_decode_timing i_sad_decode_timing (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmpRowOne(cmpRowOne), .cmpRowTwo(cmpRowTwo),
        .cmpRowThree(cmpRowThree), .samplePulse(samplePulse),
        .currentTop(currentTop), .currentMid(currentMid),
        .clock_phase_one(ph[0]), .clock_phase_two(ph[1]),
        .clock_phase_three(ph[2]), .clock_phase_four(ph[3]),
        .clock_phase_five(ph[4]), .dataWord(dataWord),
        .dataValid(dataValid));
    sad_cmp_model i_sad_cmp_model (.clk_sys(clk_sys),
        .samplePulse(samplePulse), .currentTop(currentTop),
        .currentMid(currentMid), .level(level), .cmpRowOne(cmpRowOne),
        .cmpRowTwo(cmpRowTwo), .cmpRowThree(cmpRowThree));

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string msg);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s seen %0h want %0h", $time, msg, seen, exp);
        end
    endtask

    task tally_and_finish;
        $display("Counts: %0d compares, %0d errors", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Ceiling well above the few dozen conversions run here
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task step;
        @(posedge clk_sys);
        #1;
    endtask

    task wait_valid;
        int n;
        n = 0;
        do begin
            step();
            n++;
        end while (dataValid !== 1'b1 && n < 60);
        check(n < 60, 1, "no word");
    endtask

    // Sets the level inside the sample pulse; flip changes it afterwards
    task convert(input logic [7:0] lv, input bit flip);
        wait_valid();
        repeat (2) step();
        check(samplePulse, 1, "pulse");
        level = lv;
        if (flip) begin
            repeat (SAMPLE_CYC + 1) step();
            level = ~lv;
        end
        wait_valid();
        check(dataWord, lv, "word");
        check(currentTop, lv[7:6], "top sources");
        check(currentMid, lv[5:3], "mid sources");
    endtask

    task test_levels;
        logic [7:0] tab [12] = '{8'h00, 8'h01, 8'h3f, 8'h40, 8'h7f, 8'h80,
            8'hbf, 8'hc0, 8'hff, 8'hfe, 8'h55, 8'haa};
        foreach (tab[i]) convert(tab[i], 1'b0);
        convert(8'h9d, 1'b1);
        $display("test_levels done");
    endtask

    task test_timing;
        int pulses, valids, oneHigh, fallAt, topAt, midAt;
        pulses = 0; valids = 0; oneHigh = 0;
        fallAt = -1; topAt = -1; midAt = -1;
        convert(8'h00, 1'b0);
        for (int i = 0; i < CONV_CYC; i++) begin
            step();
            if (i == 1) level = 8'hff;
            check($onehot(ph), 1, "phase ring");
            pulses += (samplePulse === 1'b1);
            valids += (dataValid === 1'b1);
            oneHigh += (ph[0] === 1'b1);
            if (pulses > 0 && samplePulse === 1'b0 && fallAt < 0) fallAt = i;
            if (currentTop !== 2'b00 && topAt < 0) topAt = i;
            if (currentMid !== 3'b000 && midAt < 0) midAt = i;
        end
        check(pulses, SAMPLE_CYC, "pulse width");
        check(oneHigh, OSC_CYC, "phase length");
        check(valids, 1, "words per period");
        check(dataValid, 1, "word at period end");
        check(topAt - fallAt, SETTLE_CYC, "first row settle");
        check(midAt > topAt, 1, "row order");
        check(dataWord, 8'hff, "full scale");
        $display("test_timing done");
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        test_levels();
        test_timing();
        tally_and_finish();
    end
endmodule
